// [logic/local_bus_cycle_control.sv]
// Local memory bus cycle control: address/status/data mux and strobes.
//
// Functional notes
// - Address and status are valid on the bus across the latch strobe fall.
// - A high fault input with ready high marks the current cycle faulted.
// - Fault with ready low means retry: rerun and re-present the address.
// - In emulation, fault suppresses all column strobes for this cycle.
// - Inbound transceiver enable is active high.
// - Outbound transceiver enable is active low.
// - Address phase: word address on bits 31..4, status on bits 3..0.
// - Data phase uses all 32 lines, bit 0 least significant.
// - Low ready makes the cycle wait.
// - Waiting ends on lost bus priority or a retry request.
// - Wait states are whole phase-one clock periods.
// - Ready extends read, write, transfer and refresh cycles.
// - Ready is ignored on internal cycles.
// - A burst is several column strobes within one row strobe.
// - Half-width low makes transfers 16 bits wide.
// - Half-width selects which data half carries the transfer.
// - In emulation, half-width selects the mapped memory size.
// - In emulation, burst-ok is used for memory mapping.
// - Termination is decoded from ready and fault together.
// - Four column strobes, one per byte lane.
`timescale 1ns/1ps
module local_bus_cycle_control #(
  parameter int PHASE1_DIV = lbus_pkg::PHASE1_DIV
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  req_valid,
  output logic                       req_ready,
  input  wire lbus_pkg::cyc_req_t    req,
  output lbus_pkg::cyc_rsp_t         rsp,
  input  wire logic                  emulation_mode,
  input  wire logic                  bus_priority,
  input  wire lbus_pkg::decode_in_t  dec,
  input  wire logic [31:0]           local_addr_data_bus_in,
  output logic [31:0]                local_addr_data_bus_out,
  output logic                       local_addr_data_bus_oe,
  output logic                       addr_latch_strobe,
  output logic                       xcvr_inbound_en,
  output logic                       xcvr_outbound_en_n,
  output logic                       row_strobe_n,
  output logic [3:0]                 col_strobe_n,
  output logic                       local_clock_phase1,
  output logic                       map_size_half,
  output logic                       map_burst_region
);

  // ----------------------------------------------------------------------
  // Phase-one divider
  // ----------------------------------------------------------------------
  localparam logic [lbus_pkg::PH_W-1:0] PH_LAST =
    lbus_pkg::PH_W'(PHASE1_DIV - 1);
  localparam logic [lbus_pkg::PH_W-1:0] PH_HALF =
    lbus_pkg::PH_W'(PHASE1_DIV / 2);

  logic [lbus_pkg::PH_W-1:0] ph_q;
  logic [lbus_pkg::PH_W-1:0] ph_d;
  logic                      tick;

  // One enable per full phase-one period; every wait is one tick.
  always_comb begin
    tick = (ph_q == PH_LAST);
    ph_d = tick ? '0 : ph_q + 1'b1;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ph_q <= '0;
    end else begin
      ph_q <= ph_d;
    end
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Route a 32-bit word onto the half selected for narrow ports.
  function automatic logic [31:0] place_half(input logic [31:0] w,
                                             input logic        hi);
    place_half = hi ? {w[15:0], 16'h0000} : w;
  endfunction

  // Cycles that honour ready; internal cycles do not.
  function automatic logic waits_on_ready(input lbus_pkg::cyc_kind_t k);
    case (k)
      lbus_pkg::CYC_READ,
      lbus_pkg::CYC_WRITE,
      lbus_pkg::CYC_XFER,
      lbus_pkg::CYC_REFRESH: waits_on_ready = 1'b1;
      default:               waits_on_ready = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Cycle state machine
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_DATA = 5'b00100,
    ST_HALF = 5'b01000,
    ST_DONE = 5'b10000
  } state_t;

  state_t              st_q, st_d;
  lbus_pkg::cyc_req_t  cur_q, cur_d;
  logic [31:0]         rdata_q, rdata_d;
  logic [1:0]          beats_q, beats_d;
  logic                upper_q, upper_d;
  logic                fault_q, fault_d;
  logic                retry_q, retry_d;
  logic                lost_q, lost_d;
  logic                wprot_q, wprot_d;
  lbus_pkg::term_t     term;
  logic                internal;

  assign internal = !waits_on_ready(cur_q.kind);

  lbus_term_decode u_term (
    .ready    (dec.ready),
    .fault    (dec.fault),
    .internal (internal),
    .term     (term)
  );

  // Requests are taken only on a phase boundary, so the address phase always
  // spans a full phase-one period and the latch strobe pulse is never lost.
  assign req_ready = (st_q == ST_IDLE) && tick;

  // Next-state logic; all moves happen on phase-one ticks only.
  always_comb begin
    st_d    = st_q;
    cur_d   = cur_q;
    rdata_d = rdata_q;
    beats_d = beats_q;
    upper_d = upper_q;
    fault_d = fault_q;
    retry_d = retry_q;
    lost_d  = lost_q;
    wprot_d = wprot_q;
    if (st_q == ST_IDLE && req_valid && tick) begin
      cur_d   = req;
      beats_d = req.burst_len;
      upper_d = 1'b0;
      fault_d = 1'b0;
      retry_d = 1'b0;
      lost_d  = 1'b0;
      wprot_d = 1'b0;
      st_d    = ST_ADDR;
    end else if (tick) begin
      case (st_q)
        ST_ADDR: st_d = ST_DATA;
        ST_DATA, ST_HALF: begin
          if (!bus_priority && term == lbus_pkg::TERM_WAIT) begin
            lost_d = 1'b1;
            st_d   = ST_DONE;
          end else begin
            case (term)
              lbus_pkg::TERM_WAIT: st_d = st_q;
              lbus_pkg::TERM_RETRY: begin
                retry_d = 1'b1;
                upper_d = 1'b0;
                st_d    = ST_ADDR;
              end
              lbus_pkg::TERM_FAULT: begin
                fault_d = 1'b1;
                wprot_d = emulation_mode;
                st_d    = ST_DONE;
              end
              default: begin
                if (st_q == ST_HALF) begin
                  rdata_d[31:16] = local_addr_data_bus_in[15:0];
                end else if (!dec.half_n) begin
                  rdata_d = {16'h0000, local_addr_data_bus_in[15:0]};
                end else begin
                  rdata_d = local_addr_data_bus_in;
                end
                if (!dec.half_n && st_q == ST_DATA && internal == 1'b0) begin
                  upper_d = 1'b1;
                  st_d    = ST_HALF;
                end else if (beats_q != 2'd0 && !dec.burst_ok_n &&
                             !emulation_mode) begin
                  beats_d      = beats_q - 2'd1;
                  cur_d.waddr  = cur_q.waddr + 28'd1;
                  upper_d      = 1'b0;
                  st_d         = ST_DATA;
                end else begin
                  st_d = ST_DONE;
                end
              end
            endcase
          end
        end
        ST_DONE: st_d = ST_IDLE;
        default: st_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= ST_IDLE;
      cur_q   <= '0;
      rdata_q <= lbus_pkg::BUS_RESET;
      beats_q <= '0;
      upper_q <= 1'b0;
      fault_q <= 1'b0;
      retry_q <= 1'b0;
      lost_q  <= 1'b0;
      wprot_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      cur_q   <= cur_d;
      rdata_q <= rdata_d;
      beats_q <= beats_d;
      upper_q <= upper_d;
      fault_q <= fault_d;
      retry_q <= retry_d;
      lost_q  <= lost_d;
      wprot_q <= wprot_d;
    end
  end

  // ----------------------------------------------------------------------
  // Pin outputs, registered
  // ----------------------------------------------------------------------
  logic [31:0] bus_q, bus_d;
  logic        oe_q, oe_d, alt_q, alt_d, in_q, in_d, out_n_q, out_n_d;
  logic        ras_n_q, ras_n_d, ph1_q, ph1_d;
  logic [3:0]  cas_n_q, cas_n_d;
  logic        is_wr;
  logic        internal_d;
  logic        new_beat;

  assign is_wr = (cur_q.kind == lbus_pkg::CYC_WRITE);

  // Strobes for the coming cycle follow the kind being loaded, so a take
  // never shows the previous request's row strobe level.
  assign internal_d = !waits_on_ready(cur_d.kind);

  // A column strobe rises for one cycle between beats; without the gap a
  // burst or second half would look like one long access to memory.
  assign new_beat = tick && (st_q == ST_ADDR || term != lbus_pkg::TERM_WAIT);

  // Strobe the latch high in the address phase and drop it one clock before its end,
  // so the falling edge sees a stable address and status.
  always_comb begin
    bus_d   = bus_q;
    oe_d    = 1'b0;
    alt_d   = 1'b0;
    in_d    = 1'b0;
    out_n_d = 1'b1;
    ras_n_d = 1'b1;
    cas_n_d = lbus_pkg::CAS_ALL_N;
    ph1_d   = (ph_d < PH_HALF);
    case (st_d)
      ST_ADDR: begin
        bus_d = {cur_d.waddr, cur_d.status};
        oe_d  = 1'b1;
        alt_d = (ph_d != PH_LAST);
        ras_n_d = internal_d;
      end
      ST_DATA, ST_HALF: begin
        ras_n_d = internal_d;
        if (!internal_d && !wprot_d && !new_beat) begin
          cas_n_d = ~cur_d.byte_en;
        end
        if (emulation_mode && dec.fault) begin
          cas_n_d = lbus_pkg::CAS_ALL_N;
        end
        if (is_wr) begin
          bus_d   = place_half(cur_d.wdata, st_d == ST_HALF);
          oe_d    = 1'b1;
          out_n_d = 1'b0;
        end else if (!internal_d) begin
          in_d = 1'b1;
        end
      end
      default: begin
        bus_d = bus_q;
      end
    endcase
    if (in_d) begin
      out_n_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_q   <= lbus_pkg::BUS_RESET;
      oe_q    <= 1'b0;
      alt_q   <= 1'b0;
      in_q    <= 1'b0;
      out_n_q <= 1'b1;
      ras_n_q <= 1'b1;
      cas_n_q <= lbus_pkg::CAS_ALL_N;
      ph1_q   <= 1'b0;
    end else begin
      bus_q   <= bus_d;
      oe_q    <= oe_d;
      alt_q   <= alt_d;
      in_q    <= in_d;
      out_n_q <= out_n_d;
      ras_n_q <= ras_n_d;
      cas_n_q <= cas_n_d;
      ph1_q   <= ph1_d;
    end
  end

  assign local_addr_data_bus_out = bus_q;
  assign local_addr_data_bus_oe  = oe_q;
  assign addr_latch_strobe       = alt_q;
  assign xcvr_inbound_en         = in_q;
  assign xcvr_outbound_en_n      = out_n_q;
  assign row_strobe_n            = ras_n_q;
  assign col_strobe_n            = cas_n_q;
  assign local_clock_phase1      = ph1_q;

  // Emulation mapping hints follow the decode inputs directly.
  assign map_size_half    = emulation_mode & ~dec.half_n;
  assign map_burst_region = emulation_mode & ~dec.burst_ok_n;

  // Answer to the core, one cycle in the done state.
  always_comb begin
    rsp.done  = (st_q == ST_DONE) && tick;
    rsp.fault = fault_q;
    rsp.retry = retry_q;
    rsp.lost  = lost_q;
    rsp.rdata = rdata_q;
  end

endmodule // local_bus_cycle_control

// [logic/lbus_pkg.sv]
// Package of constants and carrier types for the local bus cycle control.
package lbus_pkg;

  // ----------------------------------------------------------------------
  // Bus layout
  // ----------------------------------------------------------------------
  localparam int BUS_W        = 32;
  localparam int STATUS_W     = 4;
  localparam int STATUS_LSB   = 0;
  localparam int WADDR_LSB    = 4;
  localparam int WADDR_W      = 28;
  localparam int HALF_W       = 16;
  localparam int LANES        = 4;

  // ----------------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [3:0]  CAS_IDLE_N     = 4'h0;
  localparam logic [3:0]  CAS_ALL_N      = 4'hF;
  localparam logic [31:0] BUS_RESET      = 32'h0000_0000;
  localparam int          PHASE1_DIV     = 4;
  localparam int          PH_W           = 2;
  localparam int          BURST_MAX      = 4;

  // Cycle kinds requested by the core.
  typedef enum logic [2:0] {
    CYC_READ    = 3'h0,
    CYC_WRITE   = 3'h1,
    CYC_XFER    = 3'h2,
    CYC_REFRESH = 3'h3,
    CYC_INTERNAL = 3'h4
  } cyc_kind_t;

  // Termination decoded from ready and fault.
  typedef enum logic [1:0] {
    TERM_WAIT  = 2'h0,
    TERM_OK    = 2'h1,
    TERM_FAULT = 2'h2,
    TERM_RETRY = 2'h3
  } term_t;

  // Request from the core.
  typedef struct packed {
    cyc_kind_t   kind;
    logic [27:0] waddr;
    logic [3:0]  status;
    logic [3:0]  byte_en;
    logic [31:0] wdata;
    logic [1:0]  burst_len;
  } cyc_req_t;

  // Answer to the core.
  typedef struct packed {
    logic        done;
    logic        fault;
    logic        retry;
    logic        lost;
    logic [31:0] rdata;
  } cyc_rsp_t;

  // Inputs from memory-decode logic.
  typedef struct packed {
    logic ready;
    logic fault;
    logic burst_ok_n;
    logic half_n;
  } decode_in_t;

endpackage

// [logic/lbus_term_decode.sv]
// Termination decoder for ready and fault inputs.
`timescale 1ns/1ps
module lbus_term_decode (
  input  wire logic              ready,
  input  wire logic              fault,
  input  wire logic              internal,
  output lbus_pkg::term_t        term
);

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // Internal cycles never look at ready, so they always end at once.
  always_comb begin
    if (internal) begin
      term = lbus_pkg::TERM_OK;
    end else begin
      case ({fault, ready})
        2'b00:   term = lbus_pkg::TERM_WAIT;
        2'b01:   term = lbus_pkg::TERM_OK;
        2'b10:   term = lbus_pkg::TERM_RETRY;
        default: term = lbus_pkg::TERM_FAULT;
      endcase
    end
  end

endmodule // lbus_term_decode

// [sim/lbus_monitor.sv]
// Checker of the local bus cycle control port behaviour, with its bind.
`timescale 1ns/1ps
module lbus_monitor #(
  parameter int PHASE1_DIV = 4
) (
  input wire logic                  mclk,
  input wire logic                  rst_n,
  input wire logic                  req_valid,
  input wire logic                  req_ready,
  input wire lbus_pkg::cyc_req_t    req,
  input wire lbus_pkg::cyc_rsp_t    rsp,
  input wire logic                  emulation_mode,
  input wire logic                  bus_priority,
  input wire lbus_pkg::decode_in_t  dec,
  input wire logic [31:0]           local_addr_data_bus_out,
  input wire logic                  local_addr_data_bus_oe,
  input wire logic                  addr_latch_strobe,
  input wire logic                  xcvr_inbound_en,
  input wire logic                  xcvr_outbound_en_n,
  input wire logic [3:0]            col_strobe_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  lbus_pkg::cyc_kind_t kind_q;
  lbus_pkg::cyc_kind_t kind_d;

  // Kind of the cycle in flight; ready only matters off chip.
  always_comb kind_d = (req_valid && req_ready) ? req.kind : kind_q;
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n) kind_q <= lbus_pkg::CYC_INTERNAL;
    else kind_q <= kind_d;

  // ----------------------------------------------------------------------
  // Cycle termination
  // ----------------------------------------------------------------------
  sequence s_stall;
    kind_q != lbus_pkg::CYC_INTERNAL && !dec.ready && !dec.fault
      && bus_priority;
  endsequence
  sequence s_retry;
    (dec.fault && !dec.ready && bus_priority
      && (xcvr_inbound_en || !xcvr_outbound_en_n)) [*4];
  endsequence

  ready_wait_a: assert property (s_stall [*5] |-> !rsp.done)
    else $error("cycle ended while ready held low");
  retry_rerun_a: assert property (s_retry |-> ##[1:12]
    $rose(addr_latch_strobe)) else $error("retry did not rerun address");
  internal_done_a: assert property (req_valid && req_ready
    && req.kind == lbus_pkg::CYC_INTERNAL |-> ##[1:40] rsp.done)
    else $error("internal cycle did not finish");

  // ----------------------------------------------------------------------
  // Bus direction and strobes
  // ----------------------------------------------------------------------
  xcvr_excl_a: assert property (!(xcvr_inbound_en
    && !xcvr_outbound_en_n)) else $error("both transceiver enables on");
  latch_valid_a: assert property ($fell(addr_latch_strobe) |->
    local_addr_data_bus_oe && $stable(local_addr_data_bus_out))
    else $error("address not steady at latch fall");
  addr_drive_a: assert property (addr_latch_strobe |->
    local_addr_data_bus_oe && !xcvr_inbound_en)
    else $error("address phase not driven");
  out_dir_a: assert property (!xcvr_outbound_en_n |->
    local_addr_data_bus_oe) else $error("outbound without drive");
  in_dir_a: assert property (xcvr_inbound_en |->
    !local_addr_data_bus_oe) else $error("inbound while driving");
  emu_protect_a: assert property (emulation_mode && dec.fault |=>
    col_strobe_n == 4'hF) else $error("column strobe in protected cycle");
endmodule // lbus_monitor

bind local_bus_cycle_control lbus_monitor #(.PHASE1_DIV(PHASE1_DIV))
  i_lbus_monitor (
  .mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
  .req(req), .rsp(rsp), .emulation_mode(emulation_mode),
  .bus_priority(bus_priority), .dec(dec),
  .local_addr_data_bus_out(local_addr_data_bus_out),
  .local_addr_data_bus_oe(local_addr_data_bus_oe),
  .addr_latch_strobe(addr_latch_strobe), .xcvr_inbound_en(xcvr_inbound_en),
  .xcvr_outbound_en_n(xcvr_outbound_en_n), .col_strobe_n(col_strobe_n));

// [sim/mem_decode_model.sv]
// Model of the memory-decode logic, latch and memory beyond the bus.
`timescale 1ns/1ps
module mem_decode_model (
  input  wire logic                 mclk,
  input  wire logic                 addr_latch_strobe,
  input  wire logic                 xcvr_inbound_en,
  input  wire logic [3:0]           col_strobe_n,
  input  wire logic [31:0]          bus_out,
  input  wire logic [31:0]          rd_word,
  input  wire logic                 ready_lvl,
  input  wire logic                 fault_lvl,
  input  wire logic                 burst_lvl_n,
  input  wire logic                 half_lvl_n,
  output lbus_pkg::decode_in_t      dec,
  output logic [31:0]               bus_in,
  output logic [31:0]               latched
);
  logic [31:0] last_q = '0;
  logic [3:0]  col_q  = 4'hF;
  logic [1:0]  cnt_q  = 2'h0;

  // Decode levels are set by the bench per scenario.
  assign dec = '{ready: ready_lvl, fault: fault_lvl,
                 burst_ok_n: burst_lvl_n, half_n: half_lvl_n};

  // Transparent latch: follows the bus while the strobe is high.
  always_latch if (addr_latch_strobe) latched <= bus_out;

  // Count column strobes per address so a 16-bit port can answer halves.
  always_ff @(posedge mclk) begin
    col_q <= col_strobe_n;
    last_q <= bus_in;
    if (addr_latch_strobe) cnt_q <= 2'h0;
    else if (col_strobe_n != 4'hF && col_strobe_n != col_q) cnt_q <= cnt_q + 2'h1;
  end

  // A released bus toggles each cycle so stale data never looks valid.
  always_comb begin
    if (!xcvr_inbound_en) bus_in = ~last_q;
    else if (half_lvl_n) bus_in = rd_word;
    else if (cnt_q > 2'h1) bus_in = {~rd_word[31:16], rd_word[31:16]};
    else bus_in = {~rd_word[15:0], rd_word[15:0]};
  end
endmodule // mem_decode_model

// [sim/tb_top.sv]
// Self-checking testbench for the local bus cycle control.
`timescale 1ns/1ps
module tb_top;
  localparam int DIV = 4;
  logic                 mclk, rst_n, req_valid, req_ready, emu, pri;
  logic                 rdy, flt, bok_n, hlf_n, bus_oe, latch, din, dout_n;
  logic                 row_n, ph1, msh, mbr;
  logic [3:0]           col_n, cs;
  logic [31:0]          rd_word, bus_in, bus_out, held, addr_seen, data_seen;
  lbus_pkg::cyc_req_t   rq;
  lbus_pkg::cyc_rsp_t   rsp;
  lbus_pkg::decode_in_t dec;
  int                   errors, checks, lat, nlat, nbeat;

  local_bus_cycle_control #(.PHASE1_DIV(DIV)) i_local_bus_cycle_control (
    .mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req(rq), .rsp(rsp), .emulation_mode(emu),
    .bus_priority(pri), .dec(dec), .local_addr_data_bus_in(bus_in),
    .local_addr_data_bus_out(bus_out), .local_addr_data_bus_oe(bus_oe),
    .addr_latch_strobe(latch), .xcvr_inbound_en(din),
    .xcvr_outbound_en_n(dout_n), .row_strobe_n(row_n), .col_strobe_n(col_n),
    .local_clock_phase1(ph1), .map_size_half(msh), .map_burst_region(mbr));
  mem_decode_model i_mem_decode_model (
    .mclk(mclk), .addr_latch_strobe(latch), .xcvr_inbound_en(din),
    .col_strobe_n(col_n), .bus_out(bus_out), .rd_word(rd_word),
    .ready_lvl(rdy), .fault_lvl(flt), .burst_lvl_n(bok_n),
    .half_lvl_n(hlf_n), .dec(dec), .bus_in(bus_in), .latched(held));

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // One cycle: ready low nw cycles, fault high nf cycles.
  // The request is raised only while the design shows it will take it,
  // so every take falls on a phase boundary and latencies compare.
  task automatic cyc(input lbus_pkg::cyc_kind_t k, input logic [1:0] bl,
                     input int nw, input int nf);
    logic       lq;
    logic [3:0] cq;
    int         n;
    for (n = 0; n < 20 && req_ready !== 1'b1; n++) begin
      @(negedge mclk);
    end
    if (n >= 20) begin
      errors++;
      finish_test();
    end
    rq.kind = k;
    rq.burst_len = bl;
    req_valid = 1'b1;
    rdy = (nw == 0);
    flt = (nf > 0);
    @(negedge mclk);
    req_valid = 1'b0;
    chk("phase1", 32'h1, {31'h0, ph1});
    lq = 1'b0;
    cq = 4'hF;
    nlat = 0;
    nbeat = 0;
    for (lat = 1; lat < 200 && rsp.done !== 1'b1; lat++) begin
      rdy = (lat >= nw);
      flt = (lat < nf);
      if (lq && !latch) nlat++;
      if (lq && !latch) addr_seen = held;
      if (col_n != 4'hF && col_n != cq) begin
        nbeat++;
        cs = col_n;
        chk("row_low", '0, {31'h0, row_n});
      end
      if (dout_n === 1'b0 && nbeat <= 1) data_seen = bus_out;
      lq = latch;
      cq = col_n;
      @(negedge mclk);
    end
    rdy = 1'b1;
    flt = 1'b0;
    if (lat >= 200) begin
      errors++;
      finish_test();
    end
  endtask

  task automatic t_write();
    rq = '{lbus_pkg::CYC_WRITE, 28'hABC_DEF1, 4'h5, 4'h6, 32'h1234_5678, 2'h0};
    cyc(lbus_pkg::CYC_WRITE, 2'h0, 0, 0);
    chk("addr", {rq.waddr, rq.status}, addr_seen);
    chk("wdata", rq.wdata, data_seen);
    chk("lanes", {28'h0, ~rq.byte_en}, {28'h0, cs});
    chk("fault", '0, {31'h0, rsp.fault});
    $display("end write");
  endtask

  task automatic t_read(input logic half_n);
    hlf_n = half_n;
    rd_word = 32'h8421_7E3C;
    cyc(lbus_pkg::CYC_READ, 2'h0, 0, 0);
    chk("rdata", rd_word, rsp.rdata);
    hlf_n = 1'b1;
    $display("end read");
  endtask

  // Waited cycles must end a whole number of phase periods later.
  task automatic t_wait();
    int base;
    for (int k = 0; k < 4; k++) begin
      cyc(lbus_pkg::cyc_kind_t'(k), 2'h0, 0, 0);
      base = lat;
      cyc(lbus_pkg::cyc_kind_t'(k), 2'h0, base, 0);
      chk("wait_mod", '0, 32'((lat - base) % DIV));
      chk("wait_ext", 32'h1, {31'h0, lat > base});
    end
    $display("end wait");
  endtask

  task automatic t_term();
    cyc(lbus_pkg::CYC_INTERNAL, 2'h0, 150, 0);
    chk("int_lost", '0, {31'h0, rsp.lost});
    cyc(lbus_pkg::CYC_WRITE, 2'h0, 0, 100);
    chk("fault", 32'h1, {31'h0, rsp.fault});
    cyc(lbus_pkg::CYC_READ, 2'h0, 14, 14);
    chk("retry", 32'h1, {31'h0, nlat >= 2});
    chk("re_addr", {rq.waddr, rq.status}, addr_seen);
    pri = 1'b0;
    cyc(lbus_pkg::CYC_READ, 2'h0, 100, 0);
    chk("lost", 32'h1, {31'h0, rsp.lost});
    pri = 1'b1;
    $display("end term");
  endtask

  task automatic t_emul_burst();
    bok_n = 1'b0;
    cyc(lbus_pkg::CYC_WRITE, 2'h2, 0, 0);
    chk("beats", 32'h3, nbeat);
    chk("one_addr", 32'h1, nlat);
    emu = 1'b1;
    hlf_n = 1'b0;
    @(negedge mclk);
    chk("map_size", 32'h1, {31'h0, msh});
    chk("map_burst", 32'h1, {31'h0, mbr});
    cyc(lbus_pkg::CYC_WRITE, 2'h0, 0, 100);
    chk("cas_off", '0, nbeat);
    emu = 1'b0;
    hlf_n = 1'b1;
    bok_n = 1'b1;
    $display("end emul_burst");
  endtask

  // Reset for 16 cycles, then the scenarios in turn.
  initial begin
    {rst_n, req_valid, emu, flt} = '0;
    {pri, rdy, bok_n, hlf_n} = '1;
    rq = '0;
    rd_word = '0;
    errors = 0;
    checks = 0;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    t_write();
    t_read(1'b1);
    t_read(1'b0);
    t_wait();
    t_term();
    t_emul_burst();
    finish_test();
  end
endmodule // tb_top
